// >>> rtl/aomc_pkg.sv
// Constants, types and register map of the output mode configuration bank
// Operation
// - Channel C source picked by pattern code
// - Eleven-bit toggle alternates 10101010101 and 01010101010
// - Eleven-bit ramp steps every eighth cycle
// - Burst ramp steps every cycle to 16383
// - Custom word uses bits 13:3 or 13:0
// - Custom word split over two registers
// - Offset correction centres mid-scale at 1023
// - High-resolution count is two to 10+NH
// - Low-resolution count is two to 13+NH+NL
// - Auto burst bit enables burst mode
// - Digital enable gates offset correction
// - Band select: clear 90 MHz, set 45
// - Burst enabled per channel pair
// - Burst LSB replaced by overrange flag
// - Noise shaping off works only when overridden
// - Noise shaping follows pin or register bit
// - Overrange source: fast or normal flag
// - Global power-down, slow 100 us wake
// - Shutdown pin role: standby or power-down
// - Skew code maps to signed picoseconds
// - Quick overload threshold, flag after seven cycles
package aomc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFFSET_CORRECTION_CONTROL = 8'h3D;
  localparam logic [7:0] CUSTOM_WORD_UPPER         = 8'h3F;
  localparam logic [7:0] CUSTOM_WORD_LOWER         = 8'h40;
  localparam logic [7:0] BURST_HIGH_COUNT_CONTROL  = 8'h41;
  localparam logic [7:0] DIGITAL_FEATURE_CONTROL   = 8'h42;
  localparam logic [7:0] BURST_MODE_CONTROL        = 8'h44;
  localparam logic [7:0] OVERRANGE_POWER_CONTROL   = 8'h45;
  localparam logic [7:0] OUTPUT_CLOCK_DELAY_AB     = 8'hA9;
  localparam logic [7:0] OUTPUT_CLOCK_DELAY_CD     = 8'hAC;
  localparam logic [7:0] QUICK_OVERLOAD_THRESHOLD  = 8'hC3;
  localparam logic [7:0] CHANNEL_C_PATTERN         = 8'h37;
  localparam logic [7:0] OFFSET_HELPER_CONTROL     = 8'hCF;
  localparam logic [7:0] NOISE_SHAPING_OVERRIDE    = 8'hEA;

  // ----------------------------------------------------------------
  // Writable bit masks, reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] MASK_OFFS_CTL  = 8'h20;
  localparam logic [7:0] MASK_CW_HI     = 8'h3F;
  localparam logic [7:0] MASK_BURST_HI  = 8'h1F;
  localparam logic [7:0] MASK_DIG_CTL   = 8'h0F;
  localparam logic [7:0] MASK_BURST_CTL = 8'hC5;
  localparam logic [7:0] MASK_OVR_PWR   = 8'h0D;
  localparam logic [7:0] MASK_SKEW_AB   = 8'h0F;
  localparam logic [7:0] MASK_SKEW_CD   = 8'h78;
  localparam logic [7:0] MASK_PAT_C     = 8'h07;
  localparam logic [7:0] MASK_HELPER    = 8'h08;
  localparam logic [7:0] MASK_NS_OVRD   = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OFFS_SEL_BIT   = 5;
  localparam int AUTO_BURST_BIT = 0;
  localparam int NH_LSB         = 1;
  localparam int DIG_EN_BIT     = 3;
  localparam int BAND_BIT       = 2;
  localparam int BURST_CD_BIT   = 7;
  localparam int BURST_AB_BIT   = 6;
  localparam int BURST_OVR_BIT  = 2;
  localparam int NS_OFF_BIT     = 0;
  localparam int OVERRANGE_SOURCE_SELECT_BIT    = 3;
  localparam int GPD_BIT        = 2;
  localparam int PIN_ROLE_BIT   = 0;
  localparam int SKEW_CD_LSB    = 3;
  localparam int HELPER_BIT     = 3;
  localparam int NS_OVRD_BIT    = 7;

  // ----------------------------------------------------------------
  // Pattern codes, data constants, exponents
  // ----------------------------------------------------------------
  localparam logic [2:0]  PAT_NORMAL = 3'h0;
  localparam logic [2:0]  PAT_ZEROS  = 3'h1;
  localparam logic [2:0]  PAT_ONES   = 3'h2;
  localparam logic [2:0]  PAT_TOGGLE = 3'h3;
  localparam logic [2:0]  PAT_RAMP   = 3'h4;
  localparam logic [2:0]  PAT_CUSTOM = 3'h5;
  localparam logic [10:0] TOG11_A    = 11'h555;
  localparam logic [10:0] TOG11_B    = 11'h2AA;
  localparam logic [13:0] TOG14_A    = 14'h1555;
  localparam logic [13:0] TOG14_B    = 14'h2AAA;
  localparam logic [11:0] MID_CODE11 = 12'h3FF;
  localparam logic [13:0] MID_SCALE  = 14'h2000;
  localparam logic [18:0] AVG_RESET  = 19'h4_0000;
  localparam logic [4:0]  HI_EXP_BASE = 5'h0A;
  localparam logic [4:0]  LO_EXP_BASE = 5'h0D;
  localparam logic [8:0]  QOL_SCALE   = 9'h0FF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 10;
  localparam int WAKE_PD_US   = 100;
  localparam int WAKE_SB_US   = 10;
  localparam int WAKE_PD_CYC  = WAKE_PD_US * CLK_MHZ;
  localparam int WAKE_SB_CYC  = WAKE_SB_US * CLK_MHZ;
  localparam int QOL_DELAY    = 7;

  // Skew in ps per delay code, index 15 first
  localparam logic [15:0][9:0] SKEW_PS_TABLE = {
    10'h0AA, 10'h0C8, 10'h06E, 10'h08C, 10'h12C, 10'h154, 10'h0E6, 10'h10E,
    10'h392, 10'h3BA, 10'h34C, 10'h36A, 10'h01E, 10'h046, 10'h3E2, 10'h000};

  // Power states, Gray along on -> down/standby -> wake; wake -> on flips both bits
  typedef enum logic [1:0] {
    PWR_ON   = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_WAKE = 2'b11,
    PWR_STBY = 2'b10
  } aomc_pwr_e;

endpackage : aomc_pkg

// >>> rtl/aomc_top.sv
// Output mode configuration bank with pattern, offset and overrange data path
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module aomc_top
  import aomc_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic [3:0][13:0] conv_data,
  input  wire logic [3:0]       normal_ovr,
  input  wire logic             shutdown_pin,
  input  wire logic             noise_shaping_pin,
  output logic      [3:0][13:0] out_data,
  output logic      [3:0]       overrange_flag,
  output logic                  data_ready,
  output logic                  noise_shaping_on,
  output logic                  noise_band_45,
  output logic                  burst_on_pair_ab,
  output logic                  burst_on_pair_cd,
  output logic      [4:0]       high_res_exp,
  output logic      [4:0]       low_res_exp,
  output logic                  global_powerdown,
  output logic                  standby,
  output logic      [9:0]       skew_ab_ps,
  output logic      [9:0]       skew_cd_ps
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       offs_ctl;   // Offset correction control
    logic [7:0]       cw_hi;      // Custom word bits 13:8
    logic [7:0]       cw_lo;      // Custom word bits 7:0
    logic [7:0]       burst_hi;   // High-res exponent, auto burst
    logic [7:0]       dig_ctl;    // Digital enable, band, low-res exponent
    logic [7:0]       burst_ctl;  // Pair enables, LSB flag, noise off
    logic [7:0]       ovr_pwr;    // Overrange select, power control
    logic [7:0]       skew_ab;    // Clock skew pair AB
    logic [7:0]       skew_cd;    // Clock skew pair CD
    logic [7:0]       qol;        // Quick overload level
    logic [7:0]       pat_c;      // Channel C source select
    logic [7:0]       helper;     // Offset helper bit
    logic [7:0]       ns_ovrd;    // Noise shaping register control
    logic [7:0]       rdata;      // Read data, one cycle
    logic [1:0]       pdn_sync;   // Shutdown pin synchroniser
    logic [1:0]       nsp_sync;   // Noise shaping pin synchroniser
    logic [13:0]      ramp;       // Ramp counter
    logic             toggle;     // Toggle phase
    aomc_pwr_e        pstate;     // Power state
    logic [9:0]       wake_cnt;   // Wake countdown
    logic [3:0][5:0]  qpipe;      // Quick overload delay line
    logic [3:0][18:0] avg;        // Running mid-scale estimate
    logic [3:0][13:0] dout;       // Output samples
    logic [3:0]       ovr;        // Overrange flags
    logic             ready;      // Data valid
    logic             ns_on;      // Noise shaping active
    logic             band45;     // 45 MHz band
    logic             burst_ab;   // Burst pair AB
    logic             burst_cd;   // Burst pair CD
    logic [4:0]       hi_exp;     // High-res exponent
    logic [4:0]       lo_exp;     // Low-res exponent
    logic             gpd;        // Global power-down
    logic             stby;       // Standby
    logic [9:0]       skab;       // Skew AB in ps
    logic [9:0]       skcd;       // Skew CD in ps
  } aomc_state_s;

  aomc_state_s st_reg;   // Registered state
  aomc_state_s st_next;  // Next state

  logic [3:0]       qdet;     // Quick overload detected this cycle
  logic [3:0]       ovr_sel;  // Selected overrange flag
  logic             pd_req;   // Power-down requested
  logic             sb_req;   // Standby requested

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [14:0] mag;
    logic [21:0] lhs;
    logic [21:0] rhs;
    logic [19:0] diff;
    logic [12:0] corr;
    logic [10:0] x11;
    logic        dig_on;
    logic        burst_ch;
    logic [13:0] d;
    mag      = '0;
    lhs      = '0;
    rhs      = '0;
    diff     = '0;
    corr     = '0;
    x11      = '0;
    dig_on   = 1'b0;
    burst_ch = 1'b0;
    d        = '0;
    st_next  = st_reg;
    qdet     = '0;
    ovr_sel  = '0;

    // Register writes, reserved bits forced to zero
    // reserved bits held zero
    if (reg_wr)
    begin
      case (reg_addr)
        OFFSET_CORRECTION_CONTROL: st_next.offs_ctl  = reg_wdata & MASK_OFFS_CTL;
        CUSTOM_WORD_UPPER:         st_next.cw_hi     = reg_wdata & MASK_CW_HI;
        CUSTOM_WORD_LOWER:         st_next.cw_lo     = reg_wdata;
        BURST_HIGH_COUNT_CONTROL:  st_next.burst_hi  = reg_wdata & MASK_BURST_HI;
        DIGITAL_FEATURE_CONTROL:   st_next.dig_ctl   = reg_wdata & MASK_DIG_CTL;
        BURST_MODE_CONTROL:        st_next.burst_ctl = reg_wdata & MASK_BURST_CTL;
        OVERRANGE_POWER_CONTROL:   st_next.ovr_pwr   = reg_wdata & MASK_OVR_PWR;
        OUTPUT_CLOCK_DELAY_AB:     st_next.skew_ab   = reg_wdata & MASK_SKEW_AB;
        OUTPUT_CLOCK_DELAY_CD:     st_next.skew_cd   = reg_wdata & MASK_SKEW_CD;
        QUICK_OVERLOAD_THRESHOLD:  st_next.qol       = reg_wdata;
        CHANNEL_C_PATTERN:         st_next.pat_c     = reg_wdata & MASK_PAT_C;
        OFFSET_HELPER_CONTROL:     st_next.helper    = reg_wdata & MASK_HELPER;
        NOISE_SHAPING_OVERRIDE:    st_next.ns_ovrd   = reg_wdata & MASK_NS_OVRD;
        default:                   st_next.rdata     = st_reg.rdata & REG_RESET;
      endcase
    end

    // Read data valid only in the cycle after the strobe
    st_next.rdata = REG_RESET;
    if (reg_rd)
    begin
      case (reg_addr)
        OFFSET_CORRECTION_CONTROL: st_next.rdata = st_reg.offs_ctl;
        CUSTOM_WORD_UPPER:         st_next.rdata = st_reg.cw_hi;
        CUSTOM_WORD_LOWER:         st_next.rdata = st_reg.cw_lo;
        BURST_HIGH_COUNT_CONTROL:  st_next.rdata = st_reg.burst_hi;
        DIGITAL_FEATURE_CONTROL:   st_next.rdata = st_reg.dig_ctl;
        BURST_MODE_CONTROL:        st_next.rdata = st_reg.burst_ctl;
        OVERRANGE_POWER_CONTROL:   st_next.rdata = st_reg.ovr_pwr;
        OUTPUT_CLOCK_DELAY_AB:     st_next.rdata = st_reg.skew_ab;
        OUTPUT_CLOCK_DELAY_CD:     st_next.rdata = st_reg.skew_cd;
        QUICK_OVERLOAD_THRESHOLD:  st_next.rdata = st_reg.qol;
        CHANNEL_C_PATTERN:         st_next.rdata = st_reg.pat_c;
        OFFSET_HELPER_CONTROL:     st_next.rdata = st_reg.helper;
        NOISE_SHAPING_OVERRIDE:    st_next.rdata = st_reg.ns_ovrd;
        default:                   st_next.rdata = REG_RESET;
      endcase
    end

    // Pin synchronisers
    st_next.pdn_sync = {st_reg.pdn_sync[0], shutdown_pin};
    st_next.nsp_sync = {st_reg.nsp_sync[0], noise_shaping_pin};

    // Pattern generators run freely
    // ramp step each cycle
    st_next.ramp   = 14'(st_reg.ramp + 14'h0001);
    st_next.toggle = ~st_reg.toggle;

    st_next.ns_on  = st_reg.ns_ovrd[NS_OVRD_BIT] ? ~st_reg.burst_ctl[NS_OFF_BIT] : st_reg.nsp_sync[1];
    st_next.band45 = st_reg.dig_ctl[BAND_BIT];
    st_next.burst_ab = st_reg.burst_hi[AUTO_BURST_BIT] & st_reg.burst_ctl[BURST_AB_BIT];
    st_next.burst_cd = st_reg.burst_hi[AUTO_BURST_BIT] & st_reg.burst_ctl[BURST_CD_BIT];
    st_next.hi_exp = 5'(HI_EXP_BASE + 5'(st_reg.burst_hi[NH_LSB +: 4]));
    st_next.lo_exp = 5'(LO_EXP_BASE + 5'(st_reg.burst_hi[NH_LSB +: 4]) + 5'(st_reg.dig_ctl[1:0]));
    st_next.skab = SKEW_PS_TABLE[st_reg.skew_ab[3:0]];
    st_next.skcd = SKEW_PS_TABLE[st_reg.skew_cd[SKEW_CD_LSB +: 4]];

    // Power control
    // power requests
    pd_req = st_reg.ovr_pwr[GPD_BIT] | (st_reg.pdn_sync[1] & st_reg.ovr_pwr[PIN_ROLE_BIT]);
    sb_req = st_reg.pdn_sync[1] & ~st_reg.ovr_pwr[PIN_ROLE_BIT];
    st_next.gpd  = pd_req;
    st_next.stby = sb_req & ~pd_req;
    case (st_reg.pstate)
      PWR_ON:
      begin
        if (pd_req)
          st_next.pstate = PWR_DOWN;
        else if (sb_req)
          st_next.pstate = PWR_STBY;
      end
      PWR_DOWN:
      begin
        if (!pd_req)
        begin
          st_next.pstate   = PWR_WAKE;
          st_next.wake_cnt = 10'(WAKE_PD_CYC - 1);
        end
      end
      PWR_STBY:
      begin
        if (pd_req)
          st_next.pstate = PWR_DOWN;
        else if (!sb_req)
        begin
          st_next.pstate   = PWR_WAKE;
          st_next.wake_cnt = 10'(WAKE_SB_CYC - 1);
        end
      end
      PWR_WAKE:
      begin
        if (pd_req)
          st_next.pstate = PWR_DOWN;
        else if (sb_req)
          st_next.pstate = PWR_STBY;
        else if (st_reg.wake_cnt == 10'h000)
          st_next.pstate = PWR_ON;
        else
          st_next.wake_cnt = 10'(st_reg.wake_cnt - 10'h001);
      end
      default:
        st_next.pstate = PWR_DOWN;
    endcase
    st_next.ready = (st_reg.pstate == PWR_ON);

    dig_on = st_reg.dig_ctl[DIG_EN_BIT] & st_reg.offs_ctl[OFFS_SEL_BIT] & st_reg.helper[HELPER_BIT];

    // Per-channel data path
    for (int ch = 0; ch < 4; ch++)
    begin
      // threshold is full scale times level over 255
      mag  = (conv_data[ch] >= MID_SCALE) ? 15'(conv_data[ch] - MID_SCALE) : 15'(MID_SCALE - conv_data[ch]);
      lhs  = 22'(mag) * 22'(QOL_SCALE);
      rhs  = 22'({st_reg.qol, 13'h0000});
      qdet[ch] = (lhs >= rhs);
      st_next.qpipe[ch] = {st_reg.qpipe[ch][4:0], qdet[ch]};
      ovr_sel[ch] = st_reg.ovr_pwr[OVERRANGE_SOURCE_SELECT_BIT] ? normal_ovr[ch] : st_reg.qpipe[ch][QOL_DELAY - 2];
      st_next.ovr[ch] = ovr_sel[ch];

      // Running mid-scale estimate of the 11-bit code
      x11  = conv_data[ch][13:3];
      diff = 20'({x11, 8'h00}) - 20'(st_reg.avg[ch]);
      st_next.avg[ch] = 19'(st_reg.avg[ch] + 19'(20'($signed(diff) >>> 8)));
      corr = 13'(13'(x11) - 13'(st_reg.avg[ch][18:8]) + 13'(MID_CODE11));
      if (corr[12])
        corr = '0;
      else if (corr[11])
        corr = 13'h07FF;

      burst_ch = (ch < 2) ? st_reg.burst_ab : st_reg.burst_cd;
      d = conv_data[ch];
      if (dig_on && !burst_ch)
        d = {corr[10:0], 3'h0};

      if (ch == 2)
      begin
        case (st_reg.pat_c[2:0])
          PAT_ZEROS:  d = 14'h0000;
          PAT_ONES:   d = burst_ch ? 14'h3FFF : 14'h3FF8;
          PAT_TOGGLE:
          begin
            if (burst_ch)
              d = st_reg.toggle ? TOG14_B : TOG14_A;
            else
              d = {st_reg.toggle ? TOG11_B : TOG11_A, 3'h0};
          end
          // ramp, slow view in 11-bit mode
          PAT_RAMP:   d = burst_ch ? st_reg.ramp : {st_reg.ramp[13:3], 3'h0};
          PAT_CUSTOM:
          begin
            if (burst_ch)
              d = {st_reg.cw_hi[5:0], st_reg.cw_lo};
            else
              d = {st_reg.cw_hi[5:0], st_reg.cw_lo[7:3], 3'h0};
          end
          default:    d = d;
        endcase
      end

      if (burst_ch && st_reg.burst_ctl[BURST_OVR_BIT])
        d[0] = ovr_sel[ch];
      st_next.dout[ch] = (st_reg.pstate == PWR_ON) ? d : 14'h0000;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg        <= '0;
      st_reg.pstate <= PWR_ON;
      st_reg.avg    <= {4{AVG_RESET}};
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from flops
  assign reg_rdata        = st_reg.rdata;
  assign out_data         = st_reg.dout;
  assign overrange_flag   = st_reg.ovr;
  assign data_ready       = st_reg.ready;
  assign noise_shaping_on = st_reg.ns_on;
  assign noise_band_45    = st_reg.band45;
  assign burst_on_pair_ab = st_reg.burst_ab;
  assign burst_on_pair_cd = st_reg.burst_cd;
  assign high_res_exp     = st_reg.hi_exp;
  assign low_res_exp      = st_reg.lo_exp;
  assign global_powerdown = st_reg.gpd;
  assign standby          = st_reg.stby;
  assign skew_ab_ps       = st_reg.skab;
  assign skew_cd_ps       = st_reg.skcd;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ramp_fast_step_a : assert property (
    ((st_reg.pat_c[2:0] == PAT_RAMP && st_reg.burst_cd && !st_reg.burst_ctl[BURST_OVR_BIT]
      && st_reg.pstate == PWR_ON) [*2])
    |=> out_data[2] == 14'($past(out_data[2]) + 14'h0001))
    else $error("burst ramp did not step by one");
  ramp_slow_step_a : assert property (
    ((st_reg.pat_c[2:0] == PAT_RAMP && !st_reg.burst_cd && st_reg.pstate == PWR_ON) [*2])
    |=> ((out_data[2][13:3] != $past(out_data[2][13:3])) == ($past(st_reg.ramp[2:0], 2) == 3'h7)))
    else $error("eleven-bit ramp step timing wrong");
  toggle_alt_a : assert property (
    ((st_reg.pat_c[2:0] == PAT_TOGGLE && !st_reg.burst_cd && st_reg.pstate == PWR_ON) [*2])
    |=> (out_data[2][13:3] == ~$past(out_data[2][13:3])) && (out_data[2][2:0] == 3'h0))
    else $error("toggle pattern did not alternate");
  custom_word_a : assert property (
    (st_reg.pat_c[2:0] == PAT_CUSTOM && !st_reg.burst_cd && st_reg.pstate == PWR_ON)
    |=> out_data[2] == {$past(st_reg.cw_hi[5:0]), $past(st_reg.cw_lo[7:3]), 3'h0})
    else $error("custom word not driven");
  noise_source_a : assert property (
    $rose(st_reg.ns_ovrd[NS_OVRD_BIT]) && st_reg.burst_ctl[NS_OFF_BIT] ##1 $stable(st_reg.burst_ctl)
    |-> !noise_shaping_on)
    else $error("noise shaping not turned off under override");
  quick_delay_a : assert property (
    (qdet[0] ##0 (!st_reg.ovr_pwr[OVERRANGE_SOURCE_SELECT_BIT]) [*7]) |=> overrange_flag[0])
    else $error("quick overload flag not seven cycles late");
  wake_load_a : assert property (
    (st_reg.pstate == PWR_DOWN && !pd_req)
    |=> st_reg.pstate == PWR_WAKE && st_reg.wake_cnt == 10'(WAKE_PD_CYC - 1) && !data_ready)
    else $error("power-down wake time not loaded");
  burst_lsb_a : assert property (
    (st_reg.burst_ab && st_reg.burst_ctl[BURST_OVR_BIT] && st_reg.pstate == PWR_ON)
    |=> out_data[0][0] == overrange_flag[0])
    else $error("burst LSB does not carry overrange");
  low_exp_a : assert property (
    $stable(st_reg.burst_hi) && $stable(st_reg.dig_ctl)
    |=> low_res_exp == 5'(LO_EXP_BASE + 5'($past(st_reg.burst_hi[4:1])) + 5'($past(st_reg.dig_ctl[1:0]))))
    else $error("low-res exponent wrong");
endmodule : aomc_top
`default_nettype wire

// >>> verification/aomc_capture.sv
// Receiver model that latches channel C samples
`timescale 1ns/100ps
`default_nettype none
module aomc_capture
  import aomc_pkg::*;
(
  input  wire logic [3:0][13:0] out_data,
  input  wire logic             data_ready,
  input  wire logic             sys_clk,
  output logic      [13:0]      cap_c
);
  // Capture only while the device marks data valid
  always_ff @(posedge sys_clk)
  begin
    if (data_ready)
      cap_c <= out_data[2];
  end
endmodule : aomc_capture
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the output mode bank
`timescale 1ns/100ps
`default_nettype none
module testbench
  import aomc_pkg::*;
;
  logic             sys_clk, rst_n, reg_wr, reg_rd, shutdown_pin, noise_shaping_pin, data_ready;
  logic             noise_shaping_on, noise_band_45, burst_on_pair_ab, burst_on_pair_cd, global_powerdown, standby;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata;
  logic [3:0][13:0] conv_data, out_data;
  logic [3:0]       normal_ovr, overrange_flag;
  logic [4:0]       high_res_exp, low_res_exp;
  logic [9:0]       skew_ab_ps, skew_cd_ps;
  logic [13:0]      cap_c, a, b;
  int               fails, checked, steps;
  // Rows: address, write value, read-back value
  logic [23:0] rows [14] = '{24'h3F_FF3F, 24'h40_A5A5, 24'h41_FF1F, 24'h42_FF0F, 24'h44_FFC5, 24'h45_FF0D,
    24'hA9_FF0F, 24'hAC_FF78, 24'h3D_FF20, 24'hC3_FFFF, 24'h37_FF07, 24'hCF_FF08, 24'hEA_FF80, 24'h50_FF00};
  // Rows: channel C source code, expected word
  logic [16:0] pats [5] = '{17'h0_1238, 17'h0_4000, 17'h0_BFF8, 17'h1_6A50, 17'h1_9238};
  aomc_top DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_data, .normal_ovr,
    .shutdown_pin, .noise_shaping_pin, .out_data, .overrange_flag, .data_ready, .noise_shaping_on, .noise_band_45,
    .burst_on_pair_ab, .burst_on_pair_cd, .high_res_exp, .low_res_exp, .global_powerdown, .standby, .skew_ab_ps,
    .skew_cd_ps);
  aomc_capture RX (.out_data, .data_ready, .sys_clk, .cap_c);
  // Compare and count
  task chk(input string n, input logic [13:0] s, input logic [13:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // One-cycle register write
  task wr(input logic [7:0] ad, input logic [7:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    cyc(1);
  endtask : wr
  // Read, data stands the cycle after
  task rd(input logic [7:0] ad, input logic [7:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {6'h00, reg_rdata}, {6'h00, e});
  endtask : rd
  // Bounded wait for wake-up
  task wait_ready(input int n);
    repeat (n)
      if (data_ready !== 1'b1)
        cyc(1);
    chk("data_ready", data_ready, 14'h0001);
  endtask : wait_ready
  task end_of_test;
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, shutdown_pin, normal_ovr} = '0;
    noise_shaping_pin = 1'b1;
    conv_data = {4{14'h2000}};
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(2);
    foreach (rows[i]) rd(rows[i][23:16], 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
      wr(rows[i][23:16], 8'h00);
    end
    wait_ready(1100);
    wr(BURST_HIGH_COUNT_CONTROL, 8'h07);
    wr(DIGITAL_FEATURE_CONTROL, 8'h06);
    wr(BURST_MODE_CONTROL, 8'h80);
    wr(OUTPUT_CLOCK_DELAY_AB, 8'h0A);
    wr(OUTPUT_CLOCK_DELAY_CD, 8'h28);
    chk("high_res_exp", high_res_exp, 14'h000D);
    chk("low_res_exp", low_res_exp, 14'h0012);
    chk("noise_band_45", noise_band_45, 14'h0001);
    chk("burst_pairs", {burst_on_pair_cd, burst_on_pair_ab}, 14'h0002);
    chk("skew_ab_ps", skew_ab_ps, 14'h0154);
    chk("skew_cd_ps", skew_cd_ps, 14'h034C);
    wr(BURST_HIGH_COUNT_CONTROL, 8'h06);
    wr(BURST_MODE_CONTROL, 8'h01);
    chk("burst_pairs", {burst_on_pair_cd, burst_on_pair_ab}, 14'h0000);
    chk("noise_shaping_on", noise_shaping_on, 14'h0001);
    wr(NOISE_SHAPING_OVERRIDE, 8'h80);
    chk("noise_shaping_on", noise_shaping_on, 14'h0000);
    wr(BURST_MODE_CONTROL, 8'h00);
    noise_shaping_pin <= 1'b0;
    cyc(4);
    chk("noise_shaping_on", noise_shaping_on, 14'h0001);
    wr(NOISE_SHAPING_OVERRIDE, 8'h00);
    chk("noise_shaping_on", noise_shaping_on, 14'h0000);
    conv_data[2] <= 14'h1238;
    wr(CUSTOM_WORD_UPPER, 8'h2A);
    wr(CUSTOM_WORD_LOWER, 8'h55);
    foreach (pats[i])
    begin
      wr(CHANNEL_C_PATTERN, {5'h00, pats[i][16:14]});
      cyc(1);
      chk("out_c", out_data[2], pats[i][13:0]);
    end
    chk("cap_c", cap_c, 14'h1238);
    wr(CHANNEL_C_PATTERN, 8'h03);
    cyc(2);
    a = out_data[2];
    cyc(1);
    chk("toggle", a ^ out_data[2], 14'h3FF8);
    chk("toggle", {13'h0000, a == 14'h2AA8 || a == 14'h1550}, 14'h0001);
    wr(CHANNEL_C_PATTERN, 8'h04);
    cyc(2);
    a = out_data[2];
    steps = 0;
    repeat (16)
    begin
      b = out_data[2];
      cyc(1);
      if (out_data[2] !== b)
        steps++;
    end
    chk("ramp_steps", steps[13:0], 14'h0002);
    chk("ramp_rise", out_data[2] - a, 14'h0010);
    wr(BURST_HIGH_COUNT_CONTROL, 8'h01);
    wr(BURST_MODE_CONTROL, 8'h80);
    cyc(1);
    a = out_data[2];
    cyc(1);
    chk("ramp_fast", out_data[2] - a, 14'h0001);
    wr(QUICK_OVERLOAD_THRESHOLD, 8'hFF);
    @(posedge sys_clk);
    conv_data[0] <= 14'h0000;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("fast_ovr", overrange_flag, 14'h0000);
    cyc(1);
    chk("fast_ovr", overrange_flag, 14'h0001);
    conv_data[0] <= 14'h1238;
    normal_ovr <= 4'h5;
    wr(OVERRANGE_POWER_CONTROL, 8'h08);
    wr(BURST_HIGH_COUNT_CONTROL, 8'h01);
    wr(BURST_MODE_CONTROL, 8'h44);
    cyc(1);
    chk("normal_ovr", overrange_flag, 14'h0005);
    chk("burst_lsb", out_data[0], 14'h1239);
    wr(BURST_MODE_CONTROL, 8'h00);
    wr(OVERRANGE_POWER_CONTROL, 8'h04);
    cyc(2);
    chk("powerdown", {global_powerdown, data_ready}, 14'h0002);
    chk("out_a", out_data[0], 14'h0000);
    wr(OVERRANGE_POWER_CONTROL, 8'h00);
    cyc(990);
    chk("data_ready", data_ready, 14'h0000);
    wait_ready(30);
    shutdown_pin <= 1'b1;
    cyc(5);
    chk("standby", {standby, global_powerdown}, 14'h0002);
    shutdown_pin <= 1'b0;
    cyc(90);
    chk("data_ready", data_ready, 14'h0000);
    wait_ready(30);
    wr(OVERRANGE_POWER_CONTROL, 8'h01);
    shutdown_pin <= 1'b1;
    cyc(5);
    chk("pin_powerdown", {standby, global_powerdown}, 14'h0001);
    shutdown_pin <= 1'b0;
    wait_ready(1100);
    wr(CUSTOM_WORD_UPPER, 8'h15);
    conv_data[0] <= 14'h2000;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    rd(CUSTOM_WORD_UPPER, 8'h00);
    wr(OFFSET_HELPER_CONTROL, 8'h08);
    wr(OFFSET_CORRECTION_CONTROL, 8'h20);
    wr(DIGITAL_FEATURE_CONTROL, 8'h08);
    chk("offset_a", out_data[0], 14'h1FF8);
    wr(DIGITAL_FEATURE_CONTROL, 8'h00);
    chk("offset_a", out_data[0], 14'h2000);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
